/* File: shared/aes_pkg.sv */
// aes_pkg: register offsets, field positions, timing counts and the byte-level cipher functions
// assumes: shared by the accelerator top and its key schedule step; no state in here
package aes_pkg;

  // word offsets on the bus slave port (low address bits only)
  localparam logic [5:0] OFS_CTRL   = 6'h00;
  localparam logic [5:0] OFS_CMD    = 6'h04;
  localparam logic [5:0] OFS_STATUS = 6'h08;
  localparam logic [5:0] OFS_DATA0  = 6'h10;
  localparam logic [5:0] OFS_DATA3  = 6'h1C;
  localparam logic [5:0] OFS_KEY0   = 6'h20;
  localparam logic [5:0] OFS_KEY7   = 6'h3C;

  // field positions
  localparam int CTRL_DECRYPT_BIT = 0;
  localparam int CTRL_KEY256_BIT  = 1;
  localparam int CMD_START_BIT    = 0;
  localparam int STATUS_BUSY_BIT  = 0;
  localparam int STATUS_DONE_BIT  = 1;

  // bus encodings
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // block timing in core clock cycles, and schedule sizes
  localparam logic [6:0] LAT_KEY128  = 7'h34;  // 52
  localparam logic [6:0] LAT_KEY256  = 7'h4B;  // 75
  localparam logic [6:0] NUM_RK128   = 7'h0B;
  localparam logic [6:0] NUM_RK256   = 7'h0F;
  localparam logic [6:0] ROUNDS128   = 7'h0A;
  localparam logic [6:0] ROUNDS256   = 7'h0E;
  localparam logic [7:0] RCON_INIT   = 8'h01;
  localparam logic [7:0] AFFINE_FWD  = 8'h63;
  localparam logic [7:0] AFFINE_INV  = 8'h05;
  localparam logic [7:0] GF_POLY     = 8'h1B;

  function automatic logic [7:0] xtime(input logic [7:0] b);
    return {b[6:0], 1'b0} ^ (b[7] ? GF_POLY : 8'h00);
  endfunction

  function automatic logic [7:0] gmul(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] p;
    logic [7:0] x;
    p = 8'h00;
    x = a;
    for (int i = 0; i < 8; i++) begin
      if (b[i]) p = p ^ x;
      x = xtime(x);
    end
    return p;
  endfunction

  function automatic logic [7:0] rotl(input logic [7:0] b, input int n);
    return (b << n) | (b >> (8 - n));
  endfunction

  // inverse as x^254; avoids two 256-entry tables at the cost of deep logic
  function automatic logic [7:0] gf_inv(input logic [7:0] x);
    logic [7:0] x2;
    logic [7:0] x3;
    logic [7:0] x12;
    logic [7:0] x240;
    x2   = gmul(x, x);
    x3   = gmul(x2, x);
    x12  = gmul(gmul(x3, x3), gmul(x3, x3));
    x240 = gmul(x12, x3);
    for (int i = 0; i < 4; i++) x240 = gmul(x240, x240);
    return gmul(gmul(x240, x12), x2);
  endfunction

  function automatic logic [7:0] sbox(input logic [7:0] b);
    logic [7:0] a;
    a = gf_inv(b);
    return a ^ rotl(a, 1) ^ rotl(a, 2) ^ rotl(a, 3) ^ rotl(a, 4) ^ AFFINE_FWD;
  endfunction

  function automatic logic [7:0] inv_sbox(input logic [7:0] b);
    return gf_inv(rotl(b, 1) ^ rotl(b, 3) ^ rotl(b, 6) ^ AFFINE_INV);
  endfunction

  function automatic logic [127:0] sub_bytes(input logic [127:0] s, input logic inv);
    logic [127:0] o;
    o = s;
    for (int i = 0; i < 16; i++) o[8*i +: 8] = inv ? inv_sbox(s[8*i +: 8]) : sbox(s[8*i +: 8]);
    return o;
  endfunction

  // byte k of the block sits at bits 127-8k down
  function automatic logic [127:0] shift_rows(input logic [127:0] s, input logic inv);
    logic [127:0] o;
    o = s;
    for (int c = 0; c < 4; c++) begin
      for (int r = 0; r < 4; r++) begin
        o[127-8*(r+4*c) -: 8] = s[127-8*(r+4*(inv ? (c+4-r)%4 : (c+r)%4)) -: 8];
      end
    end
    return o;
  endfunction

  function automatic logic [127:0] mix_cols(input logic [127:0] s, input logic inv);
    logic [127:0] o;
    logic [31:0]  coef;
    logic [7:0]   acc;
    o    = s;
    coef = inv ? 32'h0E0B0D09 : 32'h02030101;
    for (int c = 0; c < 4; c++) begin
      for (int i = 0; i < 4; i++) begin
        acc = 8'h00;
        for (int j = 0; j < 4; j++) begin
          acc = acc ^ gmul(s[127-8*(4*c+(i+j)%4) -: 8], coef[31-8*j -: 8]);
        end
        o[127-8*(4*c+i) -: 8] = acc;
      end
    end
    return o;
  endfunction

endpackage

/* File: rtl/aes_key_step.sv */
// aes_key_step: one step of the key schedule, four new words per call
// assumes: the caller registers key and round constant and steps once per cycle
`timescale 1ns/1ps
`default_nettype none
module aes_key_step (
  // schedule state in
  input  wire logic [255:0] key_in,
  input  wire logic [7:0]   rcon_in,
  input  wire logic         key256_in,
  input  wire logic         odd_in,
  // schedule state out
  output logic      [255:0] key_out,
  output logic      [7:0]   rcon_out
);

  logic [31:0]  last_w;
  logic [31:0]  rot_w;
  logic [31:0]  sub_w;
  logic [127:0] new_w;
  logic         plain_sub;

  // 128-bit key lives in the top half; 256-bit keeps two halves and shifts
  always_comb begin
    plain_sub = key256_in & odd_in;
    last_w    = key256_in ? key_in[31:0] : key_in[159:128];
    rot_w     = plain_sub ? last_w : {last_w[23:0], last_w[31:24]};
    for (int i = 0; i < 4; i++) sub_w[8*i +: 8] = aes_pkg::sbox(rot_w[8*i +: 8]);
    if (!plain_sub) sub_w = sub_w ^ {rcon_in, 24'h000000};
    new_w[127:96] = key_in[255:224] ^ sub_w;
    new_w[95:64]  = key_in[223:192] ^ new_w[127:96];
    new_w[63:32]  = key_in[191:160] ^ new_w[95:64];
    new_w[31:0]   = key_in[159:128] ^ new_w[63:32];
    key_out  = key256_in ? {key_in[127:0], new_w} : {new_w, 128'h0};
    rcon_out = plain_sub ? rcon_in : aes_pkg::xtime(rcon_in);  // odd 256-bit steps reuse it
  end

endmodule
`default_nettype wire

/* File: rtl/aes_accel.sv */
// aes_accel: block cipher accelerator behind a 32-bit bus slave port
// assumes: single core clock, bus master keeps to word writes, one block in flight at a time
`timescale 1ns/1ps
`default_nettype none
module aes_accel (
  // clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        reset_n_in,
  // bus slave, address and control
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic        hready_in,
  input  wire logic [31:0] hwdata_in,
  // bus slave, response
  output logic      [31:0] hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  // status
  output logic             busy_out,
  output logic             done_out
);

  // bus pipeline state
  logic        ap_valid_q, ap_valid_d;
  logic        ap_write_q, ap_write_d;
  logic [5:0]  ap_addr_q, ap_addr_d;
  logic [31:0] hrdata_q, hrdata_d;
  logic        hreadyout_q, hreadyout_d;
  logic        hresp_q, hresp_d;
  // software visible state
  logic        decrypt_q, decrypt_d;
  logic        key256_q, key256_d;
  logic [127:0] data_q, data_d;
  logic [255:0] key_q, key_d;
  logic        done_q, done_d;
  // engine state
  logic        busy_q, busy_d;
  logic [6:0]  cnt_q, cnt_d;
  logic [6:0]  step_q, step_d;
  logic [255:0] kreg_q, kreg_d;
  logic [7:0]  rcon_q, rcon_d;
  logic [127:0] state_q, state_d;
  logic [127:0] rk_q [0:14];
  logic        rk_we;
  logic [3:0]  rk_idx;
  // helpers
  logic        take, bad, wr, start, finish, clr_done;
  logic [255:0] kstep;
  logic [7:0]  rcon_step;
  logic [6:0]  nk, nr, lat;
  logic [3:0]  rnd;
  logic [127:0] t;

  // mapped means aligned and inside one of the register windows
  function automatic logic addr_ok(input logic [5:0] a);
    return (a[1:0] == 2'h0) && (a == aes_pkg::OFS_CTRL || a == aes_pkg::OFS_CMD ||
      a == aes_pkg::OFS_STATUS || (a >= aes_pkg::OFS_DATA0 && a <= aes_pkg::OFS_DATA3) ||
      (a >= aes_pkg::OFS_KEY0 && a <= aes_pkg::OFS_KEY7));
  endfunction

  aes_key_step u_key_step (
    .key_in    (kreg_q),
    .rcon_in   (rcon_q),
    .key256_in (key256_q),
    .odd_in    (step_q[0]),
    .key_out   (kstep),
    .rcon_out  (rcon_step)
  );

  // address phase: decode, answer reads from flops, start error responses
  always_comb begin
    take       = hsel_in & hready_in & htrans_in[1];
    bad        = ~addr_ok(haddr_in[5:0]) | (hwrite_in & (hsize_in != aes_pkg::HSIZE_WORD));
    ap_valid_d = take & ~bad;
    ap_write_d = hwrite_in;
    ap_addr_d  = haddr_in[5:0];
    hrdata_d   = 32'h00000000;
    if (take & ~bad & ~hwrite_in) begin
      if (haddr_in[5:0] == aes_pkg::OFS_CTRL) begin
        hrdata_d[aes_pkg::CTRL_DECRYPT_BIT] = decrypt_q;
        hrdata_d[aes_pkg::CTRL_KEY256_BIT]  = key256_q;
      end else if (haddr_in[5:0] == aes_pkg::OFS_STATUS) begin
        hrdata_d[aes_pkg::STATUS_BUSY_BIT] = busy_q;
        hrdata_d[aes_pkg::STATUS_DONE_BIT] = done_q;
      end else if (haddr_in[5] == 1'b0 && haddr_in[4] == 1'b1) begin
        hrdata_d = data_q[127 - 32 * haddr_in[3:2] -: 32];
      end else if (haddr_in[5] == 1'b1) begin
        hrdata_d = key_q[255 - 32 * haddr_in[4:2] -: 32];
      end
    end
    // two-cycle error answer as the bus demands: low ready first, then high
    if (!hreadyout_q) begin
      hreadyout_d = 1'b1;
      hresp_d     = 1'b1;
    end else if (take & bad) begin
      hreadyout_d = 1'b0;
      hresp_d     = 1'b1;
    end else begin
      hreadyout_d = 1'b1;
      hresp_d     = 1'b0;
    end
  end

  // data phase writes; setup registers are frozen while a block runs
  always_comb begin
    wr        = ap_valid_q & ap_write_q;
    start     = wr & ~busy_q & (ap_addr_q == aes_pkg::OFS_CMD) & hwdata_in[aes_pkg::CMD_START_BIT];
    clr_done  = wr & (ap_addr_q == aes_pkg::OFS_STATUS) & hwdata_in[aes_pkg::STATUS_DONE_BIT];
    decrypt_d = decrypt_q;
    key256_d  = key256_q;
    key_d     = key_q;
    data_d    = data_q;
    if (wr & ~busy_q) begin
      if (ap_addr_q == aes_pkg::OFS_CTRL) begin
        decrypt_d = hwdata_in[aes_pkg::CTRL_DECRYPT_BIT];
        key256_d  = hwdata_in[aes_pkg::CTRL_KEY256_BIT];
      end else if (ap_addr_q[5:4] == 2'h1) begin
        data_d[127 - 32 * ap_addr_q[3:2] -: 32] = hwdata_in;
      end else if (ap_addr_q[5]) begin
        key_d[255 - 32 * ap_addr_q[4:2] -: 32] = hwdata_in;
      end
    end
    if (finish) data_d = state_q;  // result replaces the input block
    done_d = finish | (done_q & ~clr_done & ~start);  // set wins over clear
  end

  // engine: schedule first, then rounds, then idle until the fixed count runs out
  always_comb begin
    nk      = key256_q ? aes_pkg::NUM_RK256 : aes_pkg::NUM_RK128;
    nr      = key256_q ? aes_pkg::ROUNDS256 : aes_pkg::ROUNDS128;
    lat     = key256_q ? aes_pkg::LAT_KEY256 : aes_pkg::LAT_KEY128;
    rnd     = 4'(step_q - nk);
    busy_d  = busy_q;
    cnt_d   = cnt_q;
    step_d  = step_q;
    kreg_d  = kreg_q;
    rcon_d  = rcon_q;
    state_d = state_q;
    rk_we   = 1'b0;
    rk_idx  = step_q[3:0];
    finish  = 1'b0;
    t       = 128'h0;
    if (start) begin
      busy_d = 1'b1;
      cnt_d  = lat - 7'h01;
      step_d = 7'h00;
      kreg_d = key256_q ? key_q : {key_q[255:128], 128'h0};
      rcon_d = aes_pkg::RCON_INIT;
    end else if (busy_q) begin
      step_d = step_q + 7'h01;
      if (step_q < nk) begin
        rk_we  = 1'b1;
        kreg_d = kstep;
        rcon_d = rcon_step;
      end else if (step_q == nk) begin
        state_d = data_q ^ rk_q[decrypt_q ? nr[3:0] : 4'h0];
      end else if (step_q <= nk + nr) begin
        if (!decrypt_q) begin
          t       = aes_pkg::sub_bytes(aes_pkg::shift_rows(state_q, 1'b0), 1'b0);
          state_d = (rnd == nr[3:0] ? t : aes_pkg::mix_cols(t, 1'b0)) ^ rk_q[rnd];
        end else begin
          t       = aes_pkg::sub_bytes(aes_pkg::shift_rows(state_q, 1'b1), 1'b1) ^ rk_q[nr[3:0] - rnd];
          state_d = rnd == nr[3:0] ? t : aes_pkg::mix_cols(t, 1'b1);
        end
      end
      if (cnt_q == 7'h00) begin
        busy_d = 1'b0;
        finish = 1'b1;
      end else begin
        cnt_d = cnt_q - 7'h01;
      end
    end
  end

  // round keys are data, not control, so they carry no reset
  always_ff @(posedge sys_clk_in) begin
    if (rk_we) rk_q[rk_idx] <= kreg_q[255:128];
  end

  // bus pipeline registers
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ap_valid_q  <= 1'b0;
      ap_write_q  <= 1'b0;
      ap_addr_q   <= 6'h00;
      hrdata_q    <= 32'h00000000;
      hreadyout_q <= 1'b1;
      hresp_q     <= 1'b0;
    end else begin
      ap_valid_q  <= ap_valid_d;
      ap_write_q  <= ap_write_d;
      ap_addr_q   <= ap_addr_d;
      hrdata_q    <= hrdata_d;
      hreadyout_q <= hreadyout_d;
      hresp_q     <= hresp_d;
    end
  end

  // software visible and engine registers
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      decrypt_q <= 1'b0;
      key256_q  <= 1'b0;
      data_q    <= 128'h0;
      key_q     <= 256'h0;
      done_q    <= 1'b0;
      busy_q    <= 1'b0;
      cnt_q     <= 7'h00;
      step_q    <= 7'h00;
      kreg_q    <= 256'h0;
      rcon_q    <= 8'h00;
      state_q   <= 128'h0;
    end else begin
      decrypt_q <= decrypt_d;
      key256_q  <= key256_d;
      data_q    <= data_d;
      key_q     <= key_d;
      done_q    <= done_d;
      busy_q    <= busy_d;
      cnt_q     <= cnt_d;
      step_q    <= step_d;
      kreg_q    <= kreg_d;
      rcon_q    <= rcon_d;
      state_q   <= state_d;
    end
  end

  // outputs straight from flops
  assign hrdata_out    = hrdata_q;
  assign hreadyout_out = hreadyout_q;
  assign hresp_out     = hresp_q;
  assign busy_out      = busy_q;
  assign done_out      = done_q;

endmodule
`default_nettype wire

/* File: dv/aes_accel_properties.sv */
// aes_accel_properties: timing and answer checks on the accelerator's ports
// assumes: bound to aes_accel; one clock domain, asynchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module aes_accel_properties (
  // clock and reset
  input wire logic        sys_clk_in,
  input wire logic        reset_n_in,
  // bus slave inputs
  input wire logic        hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0]  htrans_in,
  input wire logic        hwrite_in,
  input wire logic [2:0]  hsize_in,
  input wire logic        hready_in,
  input wire logic [31:0] hwdata_in,
  // design outputs
  input wire logic [31:0] hrdata_out,
  input wire logic        hreadyout_out,
  input wire logic        hresp_out,
  input wire logic        busy_out,
  input wire logic        done_out
);
  localparam int LAT_SHORT = 52;
  localparam int LAT_LONG  = 75;
  logic [6:0] run_q;
  logic [6:0] run_d;
  logic       take;
  // length of the current busy level; a stuck busy trips the cap at 76, well before the count wraps
  always_comb run_d = busy_out ? run_q + 7'h01 : 7'h00;
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) run_q <= 7'h00;
    else run_q <= run_d;
  end
  assign take = hsel_in && hready_in && htrans_in[1];
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);
  // two-cycle error answer
  sequence err_ans;
    !hreadyout_out && hresp_out ##1 hreadyout_out && hresp_out;
  endsequence
  sequence narrow_wr;
    take && hwrite_in && hsize_in != aes_pkg::HSIZE_WORD;
  endsequence
  a_busy_exact: assert property (
    $fell(busy_out) |-> run_q == LAT_SHORT || run_q == LAT_LONG) else $error("busy length wrong");
  a_busy_cap: assert property (
    run_q <= LAT_LONG) else $error("busy too long");
  a_done_rise: assert property (
    $fell(busy_out) |-> done_out) else $error("done missing at end");
  a_start_clear: assert property (
    $rose(busy_out) |-> !done_out) else $error("done kept at start");
  a_narrow_err: assert property (
    narrow_wr |=> err_ans) else $error("narrow write not refused");
  a_err_shape: assert property (
    !hreadyout_out |-> hresp_out ##1 (hreadyout_out && hresp_out)) else $error("bad error answer");
  a_cmd_reads: assert property (
    take && !hwrite_in && haddr_in[5:0] == aes_pkg::OFS_CMD |=> hrdata_out == 32'h0 && !hresp_out)
    else $error("command read not zero");
  a_resp_cause: assert property (
    $rose(hresp_out) |-> $past(take)) else $error("error with no transfer");
endmodule
bind aes_accel aes_accel_properties chk_u (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
  .hsel_in(hsel_in), .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in),
  .hsize_in(hsize_in), .hready_in(hready_in), .hwdata_in(hwdata_in), .hrdata_out(hrdata_out),
  .hreadyout_out(hreadyout_out), .hresp_out(hresp_out), .busy_out(busy_out), .done_out(done_out));
`default_nettype wire

/* File: dv/ahb_master_model.sv */
// ahb_master_model: bus master issuing one transfer at a time to the accelerator
// assumes: single slave whose readyout is fed back as hready; drives at falling edges
`timescale 1ns/1ps
`default_nettype none
module ahb_master_model (
  // clock
  input  wire logic        clk_in,
  // request
  output logic             hsel_out,
  output logic      [31:0] haddr_out,
  output logic      [1:0]  htrans_out,
  output logic             hwrite_out,
  output logic      [2:0]  hsize_out,
  output logic      [31:0] hwdata_out,
  // response
  input  wire logic [31:0] hrdata_in,
  input  wire logic        hready_in,
  input  wire logic        hresp_in
);
  // waits that ran out of their bound; the bench turns any into a failed run
  int stalls;
  // idle bus from time zero
  initial begin
    stalls     = 0;
    hsel_out   = 1'b0;
    haddr_out  = 32'h0;
    htrans_out = 2'h0;
    hwrite_out = 1'b0;
    hsize_out  = 3'h0;
    hwdata_out = 32'h0;
  end
  // released address, and write data on reads, show inverted values so stale data never looks valid
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [2:0] sz,
                      output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(negedge clk_in);
    hsel_out   = 1'b1;
    htrans_out = 2'h2;
    haddr_out  = a;
    hwrite_out = w;
    hsize_out  = sz;
    @(negedge clk_in);
    hsel_out   = 1'b0;
    htrans_out = 2'h0;
    haddr_out  = ~a;
    hwdata_out = w ? d : ~d;
    while (hready_in !== 1'b1 && n < 8) begin
      n++;
      @(negedge clk_in);
    end
    if (n == 8) stalls++;
    rd  = hrdata_in;
    err = hresp_in || n == 8;
  endtask
  // whole-word write, the only size a well-behaved master issues
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        err;
    xfer(1'b1, a, d, aes_pkg::HSIZE_WORD, rd, err);
  endtask
endmodule
`default_nettype wire

/* File: dv/aes_block_accelerator_tb.sv */
// aes_block_accelerator_tb: self-checking bench with known-answer blocks
// assumes: aes_accel, the bus master model and the bound checker are compiled before it
`timescale 1ns/1ps
`default_nettype none
module aes_block_accelerator_tb;
  logic        sys_clk, reset_n, hsel, hwrite, hready, hresp, busy, done, err;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  int          miscompares, num_checks, busy_cnt;
  localparam logic [255:0] K128 = 256'h000102030405060708090A0B0C0D0E0F << 128;
  localparam logic [255:0] K256 = 256'h000102030405060708090A0B0C0D0E0F101112131415161718191A1B1C1D1E1F;
  localparam logic [127:0] PT   = 128'h00112233445566778899AABBCCDDEEFF;
  localparam logic [127:0] CT1  = 128'h69C4E0D86A7B0430D8CDB78070B4C55A;
  localparam logic [127:0] CT2  = 128'h8EA2B7CA516745BFEAFC49904B496089;
  aes_accel dut_u (.sys_clk_in(sys_clk), .reset_n_in(reset_n), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hready_in(hready), .hwdata_in(hwdata),
    .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp), .busy_out(busy), .done_out(done));
  ahb_master_model mst_u (.clk_in(sys_clk), .hsel_out(hsel), .haddr_out(haddr), .htrans_out(htrans),
    .hwrite_out(hwrite), .hsize_out(hsize), .hwdata_out(hwdata), .hrdata_in(hrdata), .hready_in(hready),
    .hresp_in(hresp));
  // clock and busy-cycle count, sampled away from the launching edge
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  always @(negedge sys_clk) if (busy === 1'b1) busy_cnt++;
  // a bus wait that used up its bound ends the run at once as a failure
  always @(negedge sys_clk) begin
    if (mst_u.stalls != 0) begin
      miscompares++;
      wrap_up();
    end
  end
  task automatic chk(input logic [127:0] got, input logic [127:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // idle outputs after reset, command reads as zero
  task automatic t_reset();
    chk({busy, done, hready, hresp}, 4'h2, "reset outputs");
    mst_u.xfer(1'b0, 32'h4, 32'h0, 3'h2, rd, err);
    chk({err, rd}, 33'h0, "command read");
  endtask
  // unmapped read and byte write are refused and leave data untouched
  task automatic t_refuse();
    mst_u.xfer(1'b0, 32'hC, 32'h0, 3'h2, rd, err);
    chk(err, 1'b1, "unmapped read");
    mst_u.xfer(1'b0, 32'h12, 32'h0, 3'h2, rd, err);
    chk(err, 1'b1, "unaligned read");
    mst_u.xfer(1'b1, 32'h10, 32'hFF, 3'h0, rd, err);
    chk(err, 1'b1, "byte write");
    mst_u.xfer(1'b0, 32'h10, 32'h0, 3'h2, rd, err);
    chk(rd, 32'h0, "data after byte write");
  endtask
  // one block, with a stray data write and a restart while busy
  task automatic t_block(input logic k256, input logic dec, input logic [255:0] key,
                         input logic [127:0] din, input logic [127:0] exp);
    logic [127:0] res;
    res = 128'h0;
    rd  = 32'h0;
    mst_u.wr(32'h0, {30'h0, k256, dec});
    for (int i = 0; i < (k256 ? 8 : 4); i++) mst_u.wr(32'(32'h20 + 4 * i), key[255-32*i -: 32]);
    for (int i = 0; i < 4; i++) mst_u.wr(32'(32'h10 + 4 * i), din[127-32*i -: 32]);
    busy_cnt = 0;
    mst_u.wr(32'h4, 32'h1);
    mst_u.wr(32'h10, 32'hFFFFFFFF);
    mst_u.wr(32'h4, 32'h1);
    for (int n = 0; n < 40 && rd[1] !== 1'b1; n++) mst_u.xfer(1'b0, 32'h8, 32'h0, 3'h2, rd, err);
    if (rd[1] !== 1'b1) begin
      miscompares++;
      wrap_up();
    end
    chk(busy_cnt, k256 ? aes_pkg::LAT_KEY256 : aes_pkg::LAT_KEY128, "busy cycles");
    chk({busy, done}, 2'h1, "status at end");
    for (int i = 0; i < 4; i++) begin
      mst_u.xfer(1'b0, 32'(32'h10 + 4 * i), 32'h0, 3'h2, rd, err);
      res[127-32*i -: 32] = rd;
    end
    chk(res, exp, "block result");
  endtask
  // writing one to the done bit clears it
  task automatic t_clear();
    mst_u.wr(32'h8, 32'h2);
    @(negedge sys_clk);
    chk(done, 1'b0, "done cleared");
  endtask
  // reset in the middle of a block, then a command write without the start bit
  task automatic t_midreset();
    mst_u.wr(32'h4, 32'h1);
    repeat (5) @(negedge sys_clk);
    chk(busy, 1'b1, "busy before reset");
    reset_n = 1'b0;
    repeat (2) @(negedge sys_clk);
    reset_n = 1'b1;
    chk({busy, done, hready, hresp}, 4'h2, "outputs after reset");
    mst_u.xfer(1'b0, 32'h0, 32'h0, 3'h2, rd, err);
    chk({err, rd}, 33'h0, "control after reset");
    mst_u.wr(32'h4, 32'h0);
    @(negedge sys_clk);
    chk(busy, 1'b0, "command without start");
  endtask
  // reset held three cycles, then every key size and direction
  initial begin
    miscompares = 0;
    num_checks  = 0;
    busy_cnt    = 0;
    reset_n     = 1'b0;
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    reset_n = 1'b1;
    t_reset();
    t_refuse();
    t_block(1'b0, 1'b0, K128, PT, CT1);
    t_block(1'b0, 1'b1, K128, CT1, PT);
    t_block(1'b1, 1'b0, K256, PT, CT2);
    t_block(1'b1, 1'b1, K256, CT2, PT);
    t_clear();
    t_midreset();
    wrap_up();
  end
endmodule
`default_nettype wire
